// ===== core/adsc_core.sv
// converter sequencer control: registers, conversion clock, go/done sequencing, result format
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module adsc_core #(
  parameter int unsigned RES_W = adsc_pkg::RES_W
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        nrst_i,
  // register port
  input  wire logic [adsc_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [adsc_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [adsc_pkg::DATA_W-1:0] reg_rdata_o,
  // converter side
  input  wire logic                        rc_clk_i,
  input  wire logic [RES_W-1:0]            conv_code_i,
  // control and status toward the analog side
  output logic                             converter_on_o,
  output logic                             reference_select_o,
  output logic      [adsc_pkg::CHAN_W-1:0] input_channel_select_o,
  output logic                             sample_o,
  output logic                             converting_o,
  output logic                             conv_done_o
);

  // divider terminal count for a clock code; the value returned for rc codes is unused
  function automatic logic [adsc_pkg::DIV_W-1:0] div_term(
    input logic [adsc_pkg::CLKS_W-1:0] code
  );
    logic [2:0] lg;
    lg = 3'(adsc_pkg::DIV_LOG2_BASE) + {code[1:0], 1'b0} + {2'b00, code[2]};
    div_term = (adsc_pkg::DIV_ONE << lg) - adsc_pkg::DIV_ONE;
  endfunction : div_term

  // pack a result code into the high and low bytes for the chosen format
  function automatic logic [15:0] place_result(
    input logic [RES_W-1:0] code,
    input logic             right_just
  );
    if (right_just) begin
      place_result = {6'h00, code};
    end else begin
      place_result = {code, 6'h00};
    end
  endfunction : place_result

  // control state
  logic                        justify;
  logic                        refsel;
  logic [adsc_pkg::CHAN_W-1:0] chan;
  logic                        go;
  logic                        on;
  logic [adsc_pkg::CLKS_W-1:0] clk_sel;

  // result bytes and read data
  logic [7:0]                  res_hi;
  logic [7:0]                  res_lo;
  logic [7:0]                  rdata;

  // sequencer state
  adsc_pkg::adsc_state_t       state;
  logic [adsc_pkg::DIV_W-1:0]  div_cnt;
  logic [adsc_pkg::TADC_W-1:0] tad_cnt;
  logic                        rc_prev;
  logic                        done;

  // next values
  logic                        next_justify;
  logic                        next_refsel;
  logic [adsc_pkg::CHAN_W-1:0] next_chan;
  logic                        next_go;
  logic                        next_on;
  logic [adsc_pkg::CLKS_W-1:0] next_clk_sel;
  logic [7:0]                  next_res_hi;
  logic [7:0]                  next_res_lo;
  logic [7:0]                  next_rdata;
  adsc_pkg::adsc_state_t       next_state;
  logic [adsc_pkg::DIV_W-1:0]  next_div_cnt;
  logic [adsc_pkg::TADC_W-1:0] next_tad_cnt;
  logic                        next_done;

  // decoded strobes and conversion clock
  logic wr_c0;
  logic wr_c1;
  logic wr_hi;
  logic wr_lo;
  logic rc_sel;
  logic tad_tick;
  logic timing;

  assign wr_c0  = reg_wr_i && (reg_addr_i == adsc_pkg::ADDR_CTRL0);
  assign wr_c1  = reg_wr_i && (reg_addr_i == adsc_pkg::ADDR_CTRL1);
  assign wr_hi  = reg_wr_i && (reg_addr_i == adsc_pkg::ADDR_RES_HI);
  assign wr_lo  = reg_wr_i && (reg_addr_i == adsc_pkg::ADDR_RES_LO);
  // rc oscillator is independent of the system clock; only its edges are used
  assign rc_sel = (clk_sel[1:0] == adsc_pkg::CLK_RC_CODE);
  // one conversion clock period ends on each tick
  assign tad_tick = rc_sel ? (rc_clk_i && !rc_prev)
                           : (div_cnt == div_term(clk_sel));
  // divider and period counter run while a conversion or recovery is timed; settle also counts on the divider
  assign timing = (state == adsc_pkg::ST_CONVERT) || (state == adsc_pkg::ST_RECOVER);

  // register writes, sequencer and result load
  always_comb begin
    next_justify = justify;
    next_refsel  = refsel;
    next_chan    = chan;
    next_go      = go;
    next_on      = on;
    next_clk_sel = clk_sel;
    next_res_hi  = res_hi;
    next_res_lo  = res_lo;
    next_state   = state;
    next_div_cnt = div_cnt;
    next_tad_cnt = tad_cnt;
    next_done    = 1'b0;

    // software side; bit 5 of control 0 has no storage
    if (wr_c0) begin
      next_justify = reg_wdata_i[adsc_pkg::C0_JUSTIFY];
      next_refsel  = reg_wdata_i[adsc_pkg::C0_REFSEL];
      next_chan    = reg_wdata_i[adsc_pkg::C0_CHAN_LSB +: adsc_pkg::CHAN_W];
      next_on      = reg_wdata_i[adsc_pkg::C0_ON];
      // go only sticks while the converter is on
      next_go      = reg_wdata_i[adsc_pkg::C0_GO] && reg_wdata_i[adsc_pkg::C0_ON];
    end
    // only the clock field of control 1 has storage
    if (wr_c1) begin
      next_clk_sel = reg_wdata_i[adsc_pkg::C1_CLK_LSB +: adsc_pkg::CLKS_W];
    end
    // software may overwrite the result bytes between conversions
    if (wr_hi) begin
      next_res_hi = reg_wdata_i;
    end
    // low byte written on its own strobe
    if (wr_lo) begin
      next_res_lo = reg_wdata_i;
    end

    // divider restarts at every period end so each period is a full count
    if (timing) begin
      next_div_cnt = tad_tick ? '0 : div_cnt + adsc_pkg::DIV_ONE;
    end else begin
      next_div_cnt = '0;
    end

    case (state)
      // acquisition runs here while enabled
      adsc_pkg::ST_IDLE: begin
        next_tad_cnt = '0;
        if (go && on) begin
          // rc clock waits one instruction cycle so the core can go quiet
          next_state = rc_sel ? adsc_pkg::ST_SETTLE : adsc_pkg::ST_CONVERT;
        end
      end

      // one instruction cycle of quiet before an rc conversion
      adsc_pkg::ST_SETTLE: begin
        next_div_cnt = div_cnt + adsc_pkg::DIV_ONE;
        if (!go) begin
          next_state = adsc_pkg::ST_IDLE;
        end else if (div_cnt == adsc_pkg::INSTR_CLKS - adsc_pkg::DIV_ONE) begin
          next_state   = adsc_pkg::ST_CONVERT;
          next_div_cnt = '0;
        end
      end

      // eleven conversion periods, then load and report
      adsc_pkg::ST_CONVERT: begin
        if (!go) begin
          // aborted: result bytes untouched, wait before sampling again
          next_state   = adsc_pkg::ST_RECOVER;
          next_tad_cnt = '0;
          next_div_cnt = '0; // full periods of recovery, not a leftover part
        end else if (tad_tick) begin
          if (tad_cnt == adsc_pkg::CONV_TADS - 4'h1) begin
            next_state   = adsc_pkg::ST_IDLE;
            next_tad_cnt = '0;
            next_done    = 1'b1;
            // a go write in this very cycle wins and queues the next run
            next_go      = wr_c0 && reg_wdata_i[adsc_pkg::C0_GO]
                           && reg_wdata_i[adsc_pkg::C0_ON];
            // justified load lands with the go clear; hardware beats software
            {next_res_hi, next_res_lo} = place_result(conv_code_i, justify);
          end else begin
            next_tad_cnt = tad_cnt + 4'h1;
          end
        end
      end

      // two-period pause after an abort
      adsc_pkg::ST_RECOVER: begin
        if (tad_tick) begin
          if (tad_cnt == adsc_pkg::ABORT_TADS - 4'h1) begin
            // acquisition restarts by itself once idle
            next_state   = adsc_pkg::ST_IDLE;
            next_tad_cnt = '0;
          end else begin
            next_tad_cnt = tad_cnt + 4'h1;
          end
        end
      end

      default: begin
        next_state = adsc_pkg::ST_IDLE;
      end
    endcase

    // off means idle: nothing toggles and a run is dropped without done; an off write on its last tick still loads the result
    // the written value is used so not one active cycle follows an off write
    if (!next_on) begin
      next_state   = adsc_pkg::ST_IDLE;
      next_div_cnt = '0;
      next_tad_cnt = '0;
      next_done    = 1'b0;
    end
  end

  // read data appear only in the cycle after the read strobe
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i == adsc_pkg::ADDR_CTRL0) begin
        next_rdata = {justify, refsel, 1'b0, chan, go, on};
      end else if (reg_addr_i == adsc_pkg::ADDR_CTRL1) begin
        next_rdata = {1'b0, clk_sel, 4'h0};
      end else if (reg_addr_i == adsc_pkg::ADDR_RES_HI) begin
        next_rdata = res_hi;
      end else begin
        next_rdata = res_lo;
      end
    end
  end

  // control fields; go is the only bit the sequencer also writes
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      justify <= adsc_pkg::CTRL0_RST[adsc_pkg::C0_JUSTIFY];
      refsel  <= adsc_pkg::CTRL0_RST[adsc_pkg::C0_REFSEL];
      chan    <= adsc_pkg::CTRL0_RST[adsc_pkg::C0_CHAN_LSB +: adsc_pkg::CHAN_W];
      go      <= adsc_pkg::CTRL0_RST[adsc_pkg::C0_GO];
      on      <= adsc_pkg::CTRL0_RST[adsc_pkg::C0_ON];
      clk_sel <= adsc_pkg::CLKSEL_RST;
    end else begin
      justify <= next_justify;
      refsel  <= next_refsel;
      chan    <= next_chan;
      go      <= next_go;
      on      <= next_on;
      clk_sel <= next_clk_sel;
    end
  end

  // result bytes get a known zero at reset
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_hi  <= adsc_pkg::RES_RST;
      res_lo  <= adsc_pkg::RES_RST;
    end else begin
      res_hi  <= next_res_hi;
      res_lo  <= next_res_lo;
    end
  end

  // sequencer; rc_prev only feeds the edge detect of the rc clock
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state   <= adsc_pkg::ST_IDLE;
      div_cnt <= '0;
      tad_cnt <= '0;
      rc_prev <= 1'b0;
      done    <= 1'b0;
    end else begin
      state   <= next_state;
      div_cnt <= next_div_cnt;
      tad_cnt <= next_tad_cnt;
      rc_prev <= rc_clk_i;
      done    <= next_done;
    end
  end

  // read data register
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata   <= 8'h00;
    end else begin
      rdata   <= next_rdata;
    end
  end

  // outputs; the sample is left alone after a run, no discharge is issued
  assign reg_rdata_o            = rdata;
  assign converter_on_o         = on;
  assign reference_select_o     = refsel;
  assign input_channel_select_o = chan;
  assign sample_o               = on && (state == adsc_pkg::ST_IDLE);
  assign converting_o           = (state == adsc_pkg::ST_CONVERT)
                                  || (state == adsc_pkg::ST_SETTLE);
  assign conv_done_o            = done;

endmodule : adsc_core
`default_nettype wire

// ===== core/adsc_pkg.sv
// constants, field layout and state encoding of the converter sequencer control block
// Operation
// - justify bit 7 of control 0: 1 right-justified result, 0 left-justified
// - reference bit 6: 1 external reference pin, 0 supply rail
// - channel field bits 4..2 picks analog input 0 through 7
// - software sets go bit 1 to start; hardware clears it when finished
// - enable bit 0 off holds converter logic idle with no activity
// - clock field bits 6..4 of control 1 picks divider or RC clock
// - RC conversion clock is a separate oscillator of at most 500 kHz
// - unimplemented control bits read zero and ignore writes
// - left format: high byte result 9..2, low byte bits 7..6 result 1..0
// - right format: high byte bits 1..0 result 9..8, low byte result 7..0
// - conversion yields an unsigned 10-bit code of 1024 steps
// - the sample is never discharged or reset after a conversion
// - a full conversion lasts 11 conversion clock periods
// - on finish: go clears, completion flag sets, result bytes load
// - clearing go mid-conversion keeps old result; restart after 2 periods
// - with RC clock, conversion starts one instruction cycle after go
package adsc_pkg;
  localparam int unsigned ADDR_W  = 2;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned RES_W   = 10;
  localparam int unsigned CHAN_W  = 3;
  localparam int unsigned CLKS_W  = 3;
  localparam int unsigned DIV_W   = 6;
  localparam int unsigned TADC_W  = 4;

  // register indices on the plain register port
  localparam logic [1:0] ADDR_CTRL0  = 2'h0;
  localparam logic [1:0] ADDR_CTRL1  = 2'h1;
  localparam logic [1:0] ADDR_RES_HI = 2'h2;
  localparam logic [1:0] ADDR_RES_LO = 2'h3;

  // control 0 field positions
  localparam int unsigned C0_JUSTIFY  = 7;
  localparam int unsigned C0_REFSEL   = 6;
  localparam int unsigned C0_CHAN_LSB = 2;
  localparam int unsigned C0_GO       = 1;
  localparam int unsigned C0_ON       = 0;
  // control 1 field position
  localparam int unsigned C1_CLK_LSB  = 4;

  // reset values
  localparam logic [7:0]        CTRL0_RST  = 8'h00;
  localparam logic [CLKS_W-1:0] CLKSEL_RST = 3'h0;
  localparam logic [7:0]        RES_RST    = 8'h00;

  // conversion clock decode: low two code bits equal to this select the rc clock
  localparam logic [1:0]        CLK_RC_CODE = 2'h3;
  localparam logic [DIV_W-1:0]  DIV_ONE     = 6'h01;
  localparam int unsigned       DIV_LOG2_BASE = 1;

  // timing in conversion clock periods and system cycles
  localparam logic [TADC_W-1:0] CONV_TADS  = 4'hb;
  localparam logic [TADC_W-1:0] ABORT_TADS = 4'h2;
  localparam logic [DIV_W-1:0]  INSTR_CLKS = 6'h04;

  // sequencer states, gray coded along idle, settle, convert, recover
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SETTLE  = 2'b01,
    ST_CONVERT = 2'b11,
    ST_RECOVER = 2'b10
  } adsc_state_t;
endpackage : adsc_pkg

// ===== verif/adsc_asserts.sv
// port-level assertions for the converter sequencer control block
`timescale 1ns/10ps
`default_nettype none
module adsc_asserts #(
  parameter int unsigned RES_W = adsc_pkg::RES_W
) (
  input wire logic                        clk_sys_i,
  input wire logic                        nrst_i,
  input wire logic [adsc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [adsc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic                        reg_wr_i,
  input wire logic                        reg_rd_i,
  input wire logic [adsc_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic                        rc_clk_i,
  input wire logic [RES_W-1:0]            conv_code_i,
  input wire logic                        converter_on_o,
  input wire logic                        reference_select_o,
  input wire logic [adsc_pkg::CHAN_W-1:0] input_channel_select_o,
  input wire logic                        sample_o,
  input wire logic                        converting_o,
  input wire logic                        conv_done_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // go written while enabled and idle: first step of a conversion
  sequence s_go_wr;
    reg_wr_i && reg_addr_i == adsc_pkg::ADDR_CTRL0 && reg_wdata_i[1:0] == 2'h3 && sample_o;
  endsequence
  sequence s_ctrl0_wr;
    reg_wr_i && reg_addr_i == adsc_pkg::ADDR_CTRL0;
  endsequence
  go_starts_conv_a: assert property (s_go_wr |-> ##2 converting_o)
    else $error("go write did not start a conversion");
  conv_min_len_a: assert property (conv_done_o |-> $past(converting_o, 22))
    else $error("conversion ended too early");
  done_ends_conv_a: assert property (conv_done_o |-> $past(converting_o) && !converting_o)
    else $error("done without a finishing conversion");
  done_one_cycle_a: assert property (conv_done_o |=> !conv_done_o)
    else $error("done pulse longer than one cycle");
  off_is_idle_a: assert property (!converter_on_o |-> !converting_o && !sample_o)
    else $error("converter active while off");
  ctrl_fields_a: assert property (s_ctrl0_wr |=> converter_on_o == $past(reg_wdata_i[0])
    && reference_select_o == $past(reg_wdata_i[6]) && input_channel_select_o == $past(reg_wdata_i[4:2]))
    else $error("control fields not taken from write");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  unimpl_zero_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == adsc_pkg::ADDR_CTRL1
    |-> reg_rdata_o[7] == 1'b0 && reg_rdata_o[3:0] == 4'h0)
    else $error("unimplemented control bits read nonzero");
endmodule : adsc_asserts
bind adsc_core adsc_asserts #(.RES_W(RES_W)) u_asserts (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .rc_clk_i(rc_clk_i), .conv_code_i(conv_code_i),
  .converter_on_o(converter_on_o), .reference_select_o(reference_select_o),
  .input_channel_select_o(input_channel_select_o), .sample_o(sample_o),
  .converting_o(converting_o), .conv_done_o(conv_done_o));
`default_nettype wire

// ===== verif/adsc_core_tb.sv
// register-level testbench for the converter sequencer control block
`timescale 1ns/10ps
`default_nettype none
module adsc_core_tb;
  logic       clk_sys_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic [1:0] reg_addr_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic       rc_clk_i = 1'b0;
  logic [9:0] conv_code_i = 10'h000;
  logic [7:0] reg_rdata_o;
  logic [2:0] chan;
  logic       on_o, ref_o, sample_o, converting_o, conv_done_o;
  int         n_mismatch = 0;
  int         checks = 0;
  int         rc_cnt = 0;
  int         n, n0, n_low;
  logic [2:0] cs_tab [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  int         ratio  [6] = '{2, 4, 8, 16, 32, 64};
  adsc_core dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rc_clk_i(rc_clk_i), .conv_code_i(conv_code_i), .converter_on_o(on_o),
    .reference_select_o(ref_o), .input_channel_select_o(chan), .sample_o(sample_o),
    .converting_o(converting_o), .conv_done_o(conv_done_o));
  always #5 clk_sys_i = ~clk_sys_i;
  // slow rc oscillator stand-in, 400 kHz, kept under the 500 kHz ceiling
  always @(posedge clk_sys_i) begin
    rc_cnt <= (rc_cnt == 124) ? 0 : rc_cnt + 1;
    if (rc_cnt == 124) rc_clk_i <= ~rc_clk_i;
  end
  task automatic stop_test;
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // a clock edge passes after each strobe so no strobe is driven twice in one step
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr
  task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
    @(posedge clk_sys_i);
  endtask : rdc
  // configure, enable, wait for acquisition, then go and poll for done
  task automatic conv(input logic [2:0] cs, input logic [7:0] c0, input logic [9:0] code,
                      output int cyc);
    wr(2'h1, {1'b0, cs, 4'h0});
    wr(2'h0, c0);
    conv_code_i <= code;
    repeat (20) @(posedge clk_sys_i);
    wr(2'h0, c0 | 8'h02);
    cyc = 0;
    while (conv_done_o !== 1'b1 && cyc < 4000) begin
      @(posedge clk_sys_i);
      #1;
      cyc++;
    end
    if (cyc >= 4000) begin
      n_mismatch++;
      $display("mismatch at %0t: no completion", $time);
      stop_test();
    end
    @(posedge clk_sys_i);
    rdc(2'h0, c0);
  endtask : conv
  initial begin
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int a = 0; a < 4; a++) rdc(2'(a), 8'h00);
    wr(2'h0, 8'hfd);
    rdc(2'h0, 8'hdd);
    chk({on_o, ref_o, chan}, 5'h1f);
    wr(2'h1, 8'hff);
    rdc(2'h1, 8'h70);
    for (int c = 0; c < 8; c++) begin
      wr(2'h0, {3'h0, 3'(c), 2'h1});
      chk({ref_o, chan}, {1'b0, 3'(c)});
    end
    wr(2'h0, 8'h02);
    rdc(2'h0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      conv(cs_tab[i], 8'h81, 10'h2a5 ^ 10'(i), n);
      if (i == 0) n0 = n;
      chk(16'(n - n0), 16'(11 * (ratio[i] - 2)));
      rdc(2'h2, {6'h00, 2'h2});
      rdc(2'h3, 8'ha5 ^ 8'(i));
    end
    conv(3'h0, 8'h15, 10'h2a5, n);
    rdc(2'h2, 8'ha9);
    rdc(2'h3, 8'h40);
    for (int i = 0; i < 2; i++) begin
      conv(i ? 3'h7 : 3'h3, 8'h81, 10'h3c6, n);
      // one instruction cycle of settle plus 11 rc periods of 250 cycles, the first partial
      chk(n > 2500 && n < 2760, 1'b1);
      rdc(2'h2, 8'h03);
      rdc(2'h3, 8'hc6);
    end
    wr(2'h1, 8'h60);
    conv_code_i <= 10'h111;
    wr(2'h0, 8'h83);
    repeat (50) @(posedge clk_sys_i);
    wr(2'h0, 8'h81);
    #1;
    chk(sample_o, 1'b0);
    n = 0;
    n_low = 0;
    repeat (800) begin
      @(posedge clk_sys_i);
      #1;
      if (conv_done_o === 1'b1) n++;
      if (sample_o !== 1'b1) n_low++;
    end
    chk(16'(n), 16'h0000);
    // two periods of divide by 64 before sampling again, one already seen above
    chk(16'(n_low), 16'(2 * 64 - 1));
    chk(sample_o, 1'b1);
    rdc(2'h2, 8'h03);
    rdc(2'h3, 8'hc6);
    // switching off mid-conversion drops the run at once
    wr(2'h0, 8'h83);
    repeat (30) @(posedge clk_sys_i);
    wr(2'h0, 8'h80);
    #1;
    chk({converting_o, sample_o, on_o}, 3'h0);
    n = 0;
    repeat (800) begin
      @(posedge clk_sys_i);
      #1;
      if (conv_done_o === 1'b1) n++;
    end
    chk(16'(n), 16'h0000);
    rdc(2'h2, 8'h03);
    wr(2'h3, 8'h5a);
    rdc(2'h3, 8'h5a);
    stop_test();
  end
endmodule : adsc_core_tb
`default_nettype wire
